// ==== core/msr_pkg.sv ====
// constants for the miscellaneous and sync control register bank
// assumes a serial write port delivering 8-bit address and 28-bit data
package msr_pkg;
	localparam logic [7:0] MSR_ADDR_SOFT_RESET = 8'h10;
	localparam logic [7:0] MSR_ADDR_OUT_GATE = 8'h11;
	localparam logic [7:0] MSR_ADDR_SYNC_CFG = 8'h12;
	localparam logic [7:0] MSR_ADDR_SYNC_POL = 8'h13;
	localparam logic [7:0] MSR_ADDR_SUSPEND = 8'h14;
	localparam logic [7:0] MSR_ADDR_CORE_RUN = 8'h15;
	localparam logic [7:0] MSR_ADDR_OSC_RUN = 8'h16;
	localparam logic [7:0] MSR_ADDR_TEST = 8'h17;
	localparam logic [7:0] MSR_ADDR_UPD_LINE = 8'h18;
	localparam logic [7:0] MSR_ADDR_UPD_BLOCK = 8'h19;
	localparam logic [7:0] MSR_ADDR_GPO = 8'h1A;
	localparam logic [7:0] MSR_ADDR_MASTER = 8'h20;
	localparam logic [7:0] MSR_ADDR_PAIR_POL = 8'h21;
	localparam logic [7:0] MSR_ADDR_EDGES = 8'h22;
	localparam int MSR_DATA_W = 28;
	localparam int MSR_SEL_LSB = 8;
	localparam int MSR_HD_W = 13;
	localparam int MSR_VD_LSB = 13;
	localparam int MSR_VD_W = 12;
	localparam logic [9:0] MSR_SYNC_CFG_RST = 10'h001;
	localparam logic [1:0] MSR_SEL_CLAMP = 2'h0;
	localparam logic [1:0] MSR_SEL_BLANK = 2'h1;
	localparam logic [1:0] MSR_SEL_GPO = 2'h2;
	localparam logic [1:0] MSR_SEL_TEST = 2'h3;
endpackage

// ==== core/msr_sync_gen.sv ====
// master-mode sync generator: free-running pixel and line counters
// assumes one clock; rise locations come from the register bank
`timescale 1ns/100ps
`default_nettype none
module msr_sync_gen import msr_pkg::*; #(
	parameter int LINE_LEN = 1024,
	parameter int FIELD_LINES = 512
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// control
	input wire logic run_i,
	input wire logic [MSR_HD_W-1:0] hd_rise_i,
	input wire logic [MSR_VD_W-1:0] vd_rise_i,
	// generated syncs, active high
	output logic hd_o,
	output logic vd_o
);
	// refuse frame sizes the counters cannot hold
	if (LINE_LEN < 4 || LINE_LEN > 8192 || FIELD_LINES < 4 ||
	    FIELD_LINES > 4096) begin : g_bad_size
		$error("msr_sync_gen: unsupported frame size");
	end
	typedef struct packed {
		logic [MSR_HD_W-1:0] pix;
		logic [MSR_VD_W-1:0] line;
		logic hd;
		logic vd;
	} msr_gen_s;
	msr_gen_s st_ff, nxt_st;
	localparam logic [MSR_HD_W-1:0] PIX_LAST = MSR_HD_W'(LINE_LEN - 1);
	localparam logic [MSR_VD_W-1:0] LINE_LAST = MSR_VD_W'(FIELD_LINES - 1);
	// counters; sync asserts at rise location and clears when the count reaches rise plus half a line / field
	always_comb begin
		nxt_st = st_ff;
		if (!run_i) begin
			nxt_st = '0;
		end else begin
			nxt_st.pix = (st_ff.pix == PIX_LAST) ? '0 : st_ff.pix + 1'b1;
			if (st_ff.pix == PIX_LAST)
				nxt_st.line = (st_ff.line == LINE_LAST) ? '0 :
				    st_ff.line + 1'b1;
			if (st_ff.pix == hd_rise_i)
				nxt_st.hd = 1'b1;
			else if (st_ff.pix == hd_rise_i + MSR_HD_W'(LINE_LEN / 2))
				nxt_st.hd = 1'b0;
			if (st_ff.line == vd_rise_i)
				nxt_st.vd = 1'b1;
			else if (st_ff.line == vd_rise_i + MSR_VD_W'(FIELD_LINES / 2))
				nxt_st.vd = 1'b0;
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rstn_i)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end
	assign hd_o = st_ff.hd;
	assign vd_o = st_ff.vd;
endmodule
`default_nettype wire

// ==== core/msr_regs.sv ====
// miscellaneous and sync control register bank with serial write port
// assumes serial clock and data are pins sampled on the pixel clock
`timescale 1ns/100ps
`default_nettype none
module msr_regs import msr_pkg::*; #(
	parameter int LINE_LEN = 1024,
	parameter int FIELD_LINES = 512
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// three-wire serial port
	input wire logic sck_i,
	input wire logic sdata_i,
	input wire logic sl_n_i,
	// sync ball, two-way
	input wire logic sync_ball_i,
	output logic sync_ball_o,
	output logic sync_ball_oe_o,
	// vertical and horizontal sync pins, two-way
	input wire logic vd_i,
	input wire logic hd_i,
	output logic vd_o,
	output logic hd_o,
	output logic vdhd_oe_o,
	// timing sources for the sync ball mux
	input wire logic clamp_pulse_i,
	input wire logic blanking_pulse_i,
	input wire logic shutter_test_output_i,
	// controls to the rest of the device
	output logic outputs_active_o,
	output logic clock_suspend_o,
	output logic timing_core_reset_n_o,
	output logic crystal_driver_run_o,
	output logic soft_reset_o,
	output logic [MSR_DATA_W-1:0] test_bits_o
);
	// refuse frame sizes below four pixels or lines; the generator checks its own upper limits
	if (LINE_LEN < 4 || FIELD_LINES < 4) begin : g_bad_size
		$error("msr_regs: unsupported frame size");
	end
	typedef struct packed {
		logic [2:0] sck_s;
		logic [1:0] sdi_s;
		logic [1:0] sl_s;
		logic [1:0] sync_s;
		logic [1:0] vd_s;
		logic [1:0] hd_s;
		logic vd_prev;
		logic hd_prev;
		logic [35:0] shreg;
		logic [5:0] bitcnt;
		// immediate registers
		logic soft_rst;
		logic [9:0] sync_cfg;
		logic sync_pol;
		logic suspend;
		logic core_run;
		logic osc_run;
		logic [8:0] test;
		logic upd_block;
		logic master;
		logic pair_pol;
		// field registers: pending and live copies
		logic out_gate_p, out_gate;
		logic [11:0] upd_line_p, upd_line;
		logic gpo_p, general_output_value;
		logic [24:0] edges_p, edges;
		logic pend;
		logic wait_line;
		logic [11:0] line_cnt;
		// registered outputs
		logic ball_o, ball_oe;
		logic vd_out, hd_out, vdhd_oe;
		logic act;
		logic susp;
	} msr_regs_s;
	msr_regs_s st_ff, nxt_st;
	logic gen_hd, gen_vd;
	logic vd_act, hd_act, vd_fall, hd_fall, sync_act;
	logic [7:0] waddr;
	logic [MSR_DATA_W-1:0] wdata;
	logic sck_rise, wr_done, field_wr;

	// master-mode sync source
	msr_sync_gen #(
		.LINE_LEN(LINE_LEN),
		.FIELD_LINES(FIELD_LINES)
	) u_gen (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.run_i(st_ff.master & st_ff.core_run),
		.hd_rise_i(st_ff.edges[MSR_HD_W-1:0]),
		.vd_rise_i(st_ff.edges[MSR_VD_LSB +: MSR_VD_W]),
		.hd_o(gen_hd),
		.vd_o(gen_vd)
	);

	// decoded events from synchronised pins
	always_comb begin
		sck_rise = st_ff.sck_s[1] & ~st_ff.sck_s[2];
		wr_done = st_ff.sl_s[1] & (st_ff.bitcnt == 6'd36);
		// serial word: 8 address bits then 28 data bits, lsb first
		waddr = st_ff.shreg[7:0];
		wdata = st_ff.shreg[35:8];
		// a field register is written in this cycle
		field_wr = wr_done && (waddr == MSR_ADDR_OUT_GATE ||
		    waddr == MSR_ADDR_UPD_LINE || waddr == MSR_ADDR_GPO ||
		    waddr == MSR_ADDR_EDGES);
		// slave uses pins, master its own generator
		vd_act = st_ff.master ? gen_vd : (st_ff.vd_s[1] ~^ st_ff.pair_pol);
		hd_act = st_ff.master ? gen_hd : (st_ff.hd_s[1] ~^ st_ff.pair_pol);
		vd_fall = st_ff.vd_prev & ~vd_act;
		hd_fall = st_ff.hd_prev & ~hd_act;
		// external sync active level
		sync_act = st_ff.sync_cfg[0] & (st_ff.sync_s[1] ~^ st_ff.sync_pol);
	end

	// next-state logic
	always_comb begin
		nxt_st = st_ff;
		nxt_st.sck_s = {st_ff.sck_s[1:0], sck_i};
		nxt_st.sdi_s = {st_ff.sdi_s[0], sdata_i};
		nxt_st.sl_s = {st_ff.sl_s[0], sl_n_i};
		nxt_st.sync_s = {st_ff.sync_s[0], sync_ball_i};
		nxt_st.vd_s = {st_ff.vd_s[0], vd_i};
		nxt_st.hd_s = {st_ff.hd_s[0], hd_i};
		nxt_st.vd_prev = vd_act;
		nxt_st.hd_prev = hd_act;
		nxt_st.soft_rst = 1'b0; // self-clearing
		// serial shift while load strobe is low
		if (st_ff.sl_s[1]) begin
			nxt_st.bitcnt = '0;
		end else if (sck_rise && st_ff.bitcnt != 6'd36) begin
			nxt_st.shreg = {st_ff.sdi_s[1], st_ff.shreg[35:1]};
			nxt_st.bitcnt = st_ff.bitcnt + 6'd1;
		end
		// immediate writes once load goes high after the 36th bit
		if (wr_done) begin
			nxt_st.bitcnt = '0;
			if (waddr == MSR_ADDR_SOFT_RESET)
				nxt_st.soft_rst = wdata[0];
			else if (waddr == MSR_ADDR_SYNC_CFG)
				nxt_st.sync_cfg = wdata[9:0];
			else if (waddr == MSR_ADDR_SYNC_POL)
				nxt_st.sync_pol = wdata[0];
			else if (waddr == MSR_ADDR_SUSPEND)
				nxt_st.suspend = wdata[0];
			else if (waddr == MSR_ADDR_CORE_RUN)
				nxt_st.core_run = wdata[0];
			else if (waddr == MSR_ADDR_OSC_RUN)
				nxt_st.osc_run = wdata[0];
			else if (waddr == MSR_ADDR_TEST)
				nxt_st.test = wdata[8:0];
			else if (waddr == MSR_ADDR_UPD_BLOCK)
				nxt_st.upd_block = wdata[0];
			else if (waddr == MSR_ADDR_MASTER)
				nxt_st.master = wdata[0];
			else if (waddr == MSR_ADDR_PAIR_POL)
				nxt_st.pair_pol = wdata[0];
			// field registers go to pending copies
			else if (waddr == MSR_ADDR_OUT_GATE) begin
				nxt_st.out_gate_p = wdata[0];
				nxt_st.pend = 1'b1;
			end else if (waddr == MSR_ADDR_UPD_LINE) begin
				nxt_st.upd_line_p = wdata[11:0];
				nxt_st.pend = 1'b1;
			end else if (waddr == MSR_ADDR_GPO) begin
				nxt_st.gpo_p = wdata[0];
				nxt_st.pend = 1'b1;
			end else if (waddr == MSR_ADDR_EDGES) begin
				nxt_st.edges_p = wdata[24:0];
				nxt_st.pend = 1'b1;
			end
		end
		// line counter within the field
		if (vd_fall)
			nxt_st.line_cnt = '0;
		else if (hd_fall)
			nxt_st.line_cnt = st_ff.line_cnt + 12'd1;
		// field-synchronised transfer
		if (vd_fall && !st_ff.upd_block)
			nxt_st.wait_line = 1'b1;
		if (st_ff.upd_block) begin
			nxt_st.wait_line = 1'b0;
		end else if ((st_ff.wait_line || vd_fall) &&
		    ((vd_fall ? 12'd0 : st_ff.line_cnt) == st_ff.upd_line)) begin
			nxt_st.wait_line = 1'b0;
			if (st_ff.pend) begin
				nxt_st.pend = field_wr; // a write now stays pending
				nxt_st.out_gate = st_ff.out_gate_p;
				nxt_st.upd_line = st_ff.upd_line_p;
				nxt_st.general_output_value = st_ff.gpo_p;
				nxt_st.edges = st_ff.edges_p;
			end
		end
		// sync ball: input when enabled, else selected output
		nxt_st.ball_oe = ~st_ff.sync_cfg[0];
		case (st_ff.sync_cfg[MSR_SEL_LSB +: 2])
			MSR_SEL_CLAMP: nxt_st.ball_o = clamp_pulse_i & st_ff.out_gate;
			MSR_SEL_BLANK: nxt_st.ball_o = blanking_pulse_i & st_ff.out_gate;
			MSR_SEL_GPO: nxt_st.ball_o = st_ff.general_output_value;
			default: nxt_st.ball_o = shutter_test_output_i & st_ff.out_gate;
		endcase
		if (st_ff.sync_cfg[0])
			nxt_st.ball_o = 1'b0;
		// master drives both syncs at pair polarity
		nxt_st.vdhd_oe = st_ff.master;
		nxt_st.vd_out = gen_vd ~^ st_ff.pair_pol;
		nxt_st.hd_out = gen_hd ~^ st_ff.pair_pol;
		nxt_st.act = st_ff.out_gate;
		nxt_st.susp = st_ff.suspend & sync_act;
		// soft reset returns every register to default
		if (st_ff.soft_rst) begin
			nxt_st.sync_cfg = MSR_SYNC_CFG_RST;
			nxt_st.sync_pol = 1'b0;
			nxt_st.suspend = 1'b0;
			nxt_st.core_run = 1'b0;
			nxt_st.osc_run = 1'b0;
			nxt_st.test = '0;
			nxt_st.upd_block = 1'b0;
			nxt_st.master = 1'b0;
			nxt_st.pair_pol = 1'b0;
			nxt_st.out_gate_p = 1'b0;
			nxt_st.out_gate = 1'b0;
			nxt_st.upd_line_p = '0;
			nxt_st.upd_line = '0;
			nxt_st.gpo_p = 1'b0;
			nxt_st.general_output_value = 1'b0;
			nxt_st.edges_p = '0;
			nxt_st.edges = '0;
			nxt_st.pend = 1'b0;
			nxt_st.wait_line = 1'b0;
		end
	end

	// state register; power-up defaults
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			st_ff <= '0;
			// synchronisers start at idle pin levels: no false edge
			st_ff.sck_s <= 3'h0;
			st_ff.sl_s <= 2'h3;
			st_ff.vd_s <= 2'h3;
			st_ff.hd_s <= 2'h3;
			st_ff.sync_cfg <= MSR_SYNC_CFG_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// outputs straight from flip-flops
	assign sync_ball_o = st_ff.ball_o;
	assign sync_ball_oe_o = st_ff.ball_oe;
	assign vd_o = st_ff.vd_out;
	assign hd_o = st_ff.hd_out;
	assign vdhd_oe_o = st_ff.vdhd_oe;
	assign outputs_active_o = st_ff.act;
	assign clock_suspend_o = st_ff.susp;
	assign timing_core_reset_n_o = st_ff.core_run;
	assign crystal_driver_run_o = st_ff.osc_run;
	assign soft_reset_o = st_ff.soft_rst;
	assign test_bits_o = {19'h00000, st_ff.test}; // upper 19 bits tied to zero

	// soft reset clears itself and restores defaults next cycle
	property p_soft_reset;
		@(posedge clk_i) disable iff (!rstn_i)
		st_ff.soft_rst |=> !st_ff.soft_rst && st_ff.sync_cfg == MSR_SYNC_CFG_RST
		    && !st_ff.core_run;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset bad");

	// gate off forces inactive output a cycle later
	property p_gate;
		@(posedge clk_i) disable iff (!rstn_i)
		!st_ff.out_gate |=> !outputs_active_o;
	endproperty
	a_gate: assert property (p_gate) else $error("outputs not inactive");

	// sync ball direction follows enable
	property p_ball_dir;
		@(posedge clk_i) disable iff (!rstn_i)
		$stable(st_ff.sync_cfg[0]) |=>
		    sync_ball_oe_o == !$past(st_ff.sync_cfg[0]);
	endproperty
	a_ball_dir: assert property (p_ball_dir) else $error("ball direction");

	// general output code passes the live bit
	property p_gpo_sel;
		@(posedge clk_i) disable iff (!rstn_i)
		!st_ff.sync_cfg[0] && st_ff.sync_cfg[9:8] == MSR_SEL_GPO
		    |=> sync_ball_o == $past(st_ff.general_output_value);
	endproperty
	a_gpo_sel: assert property (p_gpo_sel) else $error("gpo select");

	// suspend only while sync is active
	property p_suspend;
		@(posedge clk_i) disable iff (!rstn_i)
		clock_suspend_o |-> $past(st_ff.suspend) && $past(sync_act);
	endproperty
	a_suspend: assert property (p_suspend) else $error("spurious suspend");

	// blocked field registers keep their values
	property p_block;
		@(posedge clk_i) disable iff (!rstn_i)
		st_ff.upd_block && !st_ff.soft_rst |=> $stable(st_ff.edges)
		    && $stable(st_ff.general_output_value);
	endproperty
	a_block: assert property (p_block) else $error("update not blocked");

	// field registers change only on a field event or soft reset
	property p_field;
		@(posedge clk_i) disable iff (!rstn_i)
		!st_ff.soft_rst && !vd_fall && !st_ff.wait_line |=> $stable(st_ff.general_output_value);
	endproperty
	a_field: assert property (p_field) else $error("early field update");

	// sync pins driven only in master mode
	property p_master;
		@(posedge clk_i) disable iff (!rstn_i)
		!st_ff.master |=> !vdhd_oe_o;
	endproperty
	a_master: assert property (p_master) else $error("slave drives sync");

	// a field write in the same cycle as a transfer stays pending
	property p_pend_kept;
		@(posedge clk_i) disable iff (!rstn_i)
		field_wr && !st_ff.soft_rst |=> st_ff.pend;
	endproperty
	a_pend_kept: assert property (p_pend_kept)
		else $error("field write lost");

	// waiting for the update line leaves the live copy alone
	property p_line_wait;
		@(posedge clk_i) disable iff (!rstn_i)
		st_ff.wait_line && !st_ff.upd_block && !vd_fall && !st_ff.soft_rst
		    && st_ff.line_cnt != st_ff.upd_line |=> $stable(st_ff.out_gate);
	endproperty
	a_line_wait: assert property (p_line_wait)
		else $error("update before line");

	// enabled sync input leaves the ball output low
	property p_ball_in;
		@(posedge clk_i) disable iff (!rstn_i)
		st_ff.sync_cfg[0] |=> !sync_ball_o;
	endproperty
	a_ball_in: assert property (p_ball_in)
		else $error("ball driven as input");
endmodule
`default_nettype wire

// ==== test/msr_host_model.sv ====
// host side model: writes device registers over the three-wire serial port
// assumes the device samples sck on the pixel clock and takes 36-bit words
`timescale 1ns/100ps
`default_nettype none
module msr_host_model (
	// clock
	input wire logic clk_i,
	// serial port toward the device
	output logic sck_o,
	output logic sdata_o,
	output logic sl_n_o
);
	// clocks per serial phase, at least three
	int ph = 4;

	// idle port: load high, serial clock standing low
	initial begin
		sck_o = 1'b0;
		sdata_o = 1'b0;
		sl_n_o = 1'b1;
	end

	// wait a number of pixel clocks
	task automatic hold(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// shift one word lsb first; n below 36 makes a short word
	task automatic send(input logic [7:0] a, input logic [27:0] d,
		input int n);
		logic [35:0] w;
		w = {d, a}; // address in bits 7:0, data in bits 35:8
		sl_n_o <= 1'b0;
		hold(ph);
		for (int i = 0; i < n; i++) begin
			sdata_o <= w[i];
			hold(ph);
			sck_o <= 1'b1;
			hold(ph);
			sck_o <= 1'b0;
		end
		hold(ph);
		sl_n_o <= 1'b1;
		sdata_o <= ~sdata_o; // released line shows no stale bit
		hold(8);
	endtask
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// testbench for the misc and sync control register bank
// assumes slave syncs idle high (pair polarity zero) and a 100 MHz clock
`timescale 1ns/100ps
`default_nettype none
module tb_top import msr_pkg::*;;
	localparam int LL = 16;
	logic clk, rstn, sck, sdata, sl_n, ball_i, vd_in, hd_in;
	logic clamp, blank, stest;
	logic ball_o, oe, vd_out, hd_out, vdhd_oe, act, susp, core_n, osc, srst;
	logic [MSR_DATA_W-1:0] tbits;
	int err_count = 0;
	int n_compared = 0;
	int srst_cnt = 0;
	int cyc = 0;
	int n;
	int k;
	logic vprv, hprv;

	msr_host_model host (.clk_i(clk), .sck_o(sck), .sdata_o(sdata),
		.sl_n_o(sl_n));

	msr_regs #(.LINE_LEN(LL), .FIELD_LINES(8)) DUT (.clk_i(clk),
		.rstn_i(rstn), .sck_i(sck), .sdata_i(sdata), .sl_n_i(sl_n),
		.sync_ball_i(ball_i), .sync_ball_o(ball_o), .sync_ball_oe_o(oe),
		.vd_i(vd_in), .hd_i(hd_in), .vd_o(vd_out), .hd_o(hd_out),
		.vdhd_oe_o(vdhd_oe), .clamp_pulse_i(clamp),
		.blanking_pulse_i(blank), .shutter_test_output_i(stest),
		.outputs_active_o(act), .clock_suspend_o(susp),
		.timing_core_reset_n_o(core_n), .crystal_driver_run_o(osc),
		.soft_reset_o(srst), .test_bits_o(tbits));

	// pixel clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// soft reset pulse width counter and hang limit
	always @(posedge clk) begin
		cyc++;
		if (srst === 1'b1)
			srst_cnt++;
		if (cyc == 30000) begin
			err_count++;
			conclude();
		end
	end

	task automatic conclude();
		if (err_count == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [27:0] seen,
		input logic [27:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [27:0] d);
		host.send(a, d, 36);
		tick(6);
	endtask

	// one slave sync pulse from the controller, active low
	task automatic sync_pulse(input logic vert);
		if (vert)
			vd_in <= 1'b0;
		else
			hd_in <= 1'b0;
		tick(4);
		vd_in <= 1'b1;
		hd_in <= 1'b1;
		tick(6);
	endtask

	// main sequence
	initial begin
		{rstn, ball_i, vd_in, hd_in} = 4'hF;
		{clamp, blank, stest} = 3'h0;
		rstn = 1'b0;
		tick(12);
		rstn <= 1'b1;
		tick(4);
		check("ball_oe", oe, 0);
		check("core_n", core_n, 0);
		check("osc", osc, 0);
		check("active", act, 0);
		check("vdhd_oe", vdhd_oe, 0);
		check("test", tbits, 0);
		wr(MSR_ADDR_CORE_RUN, 1);
		check("core_n", core_n, 1);
		host.ph = 3;
		wr(MSR_ADDR_OSC_RUN, 1);
		host.ph = 4;
		check("osc", osc, 1);
		host.send(MSR_ADDR_CORE_RUN, 0, 35);
		tick(6);
		check("core_n", core_n, 1);
		// output gate waits for vertical sync
		wr(MSR_ADDR_OUT_GATE, 1);
		check("active", act, 0);
		sync_pulse(1);
		check("active", act, 1);
		// sync ball as output, every source code
		for (int s = 0; s < 4; s++) begin
			wr(MSR_ADDR_SYNC_CFG, 28'(s) << MSR_SEL_LSB); // enable bit zero: ball as output
			for (int v = 0; v < 2; v++) begin
				clamp <= (s == 0) ? v[0] : ~v[0];
				blank <= (s == 1) ? v[0] : ~v[0];
				stest <= (s == 3) ? v[0] : ~v[0];
				if (s == 2) begin
					wr(MSR_ADDR_GPO, 28'(v));
					if (v == 1)
						check("gpo_early", ball_o, 0);
					sync_pulse(1);
				end
				tick(4);
				check("ball", ball_o, v[0]);
				check("ball_oe", oe, 1);
			end
		end
		// suspend follows external sync at either polarity
		wr(MSR_ADDR_SYNC_CFG, 28'h1);
		check("ball_oe", oe, 0);
		wr(MSR_ADDR_SUSPEND, 1);
		for (int p = 0; p < 2; p++) begin
			wr(MSR_ADDR_SYNC_POL, 28'(p));
			for (int b = 0; b < 2; b++) begin
				ball_i <= b[0];
				tick(5);
				check("suspend", susp, p == b);
			end
		end
		wr(MSR_ADDR_SUSPEND, 0);
		check("suspend", susp, 0);
		// blocked field updates
		wr(MSR_ADDR_UPD_BLOCK, 1);
		wr(MSR_ADDR_OUT_GATE, 0);
		sync_pulse(1);
		check("active", act, 1);
		wr(MSR_ADDR_UPD_BLOCK, 0);
		wr(MSR_ADDR_OUT_GATE, 0);
		sync_pulse(1);
		check("active", act, 0);
		// field update delayed to line two
		wr(MSR_ADDR_UPD_LINE, 2);
		sync_pulse(1);
		wr(MSR_ADDR_OUT_GATE, 1);
		sync_pulse(1);
		check("active", act, 0);
		sync_pulse(0);
		check("active", act, 0);
		sync_pulse(0);
		check("active", act, 1);
		// master mode drives both syncs, one line per LL clocks
		wr(MSR_ADDR_MASTER, 1);
		check("vdhd_oe", vdhd_oe, 1);
		n = 0;
		hprv = hd_out;
		for (int i = 0; i < 4 * LL; i++) begin
			@(posedge clk);
			if (hd_out === 1'b1 && hprv === 1'b0)
				n++;
			hprv = hd_out;
		end
		check("hd_rises", n, 4);
		// hd rise five pixels after vd rise, at either pair polarity
		wr(MSR_ADDR_EDGES, 28'h5);
		tick(300);
		for (int p = 0; p < 2; p++) begin
			wr(MSR_ADDR_PAIR_POL, 28'(p));
			vprv = vd_out;
			hprv = hd_out;
			n = -1;
			k = -1;
			for (int i = 0; i < 300; i++) begin
				@(posedge clk);
				if (vd_out === p[0] && vprv === !p[0])
					k = 0;
				else if (k >= 0)
					k++;
				if (hd_out === p[0] && hprv === !p[0] && k >= 0 && n < 0)
					n = k;
				vprv = vd_out;
				hprv = hd_out;
			end
			check("hd_rise_loc", n, 5);
		end
		wr(MSR_ADDR_MASTER, 0);
		check("vdhd_oe", vdhd_oe, 0);
		// soft reset restores defaults and clears itself
		wr(MSR_ADDR_SYNC_CFG, 28'h200);
		wr(MSR_ADDR_SOFT_RESET, 1);
		check("srst_cycles", srst_cnt, 1);
		check("core_n", core_n, 0);
		check("osc", osc, 0);
		check("active", act, 0);
		check("ball_oe", oe, 0);
		conclude();
	end
endmodule
`default_nettype wire
